// ---- ddmpc_pkg.sv ----
// Purpose: Shared constants and types for the dual converter mute and power-down control block.
// Assumes: A 40 MHz system clock and a two-wire serial link clocked by its own serial clock.
// Notes:   Field layouts of the command and control bytes are packed structs.
// What this block does
// - A channel whose power-down bit is set puts its output in high impedance once initialisation ends.
// - A muted channel outputs the low reference; its stored code is kept.
// - The asynchronous mute input mutes both channels together, regardless of the serial clock.
// - All registers stay readable and writable while channels are muted or powered down.
// - Register reads and code writes never clear mute or power-down state; only control writes and copies change it.
// - A code written during mute or power-down appears once the channel is released.
// - Command bits 5:4: 01 volatile, 10 retained, 11 both, 00 retained-to-volatile copy.
// - Control byte: bit5 mutes ch1, bit4 mutes ch0, bit1 and bit0 power them down.
// - Volatile control lives only while powered; retained control survives power loss.
// - At power-up the retained control settings are copied into the volatile control.
// - Retained control register holds zero as delivered: unmuted and powered up.
// - Power-on reset loads every volatile register from its retained counterpart.
// - Outputs are held muted during the power-on initialisation interval of 500 us.
// - After initialisation, outputs follow the loaded settings and codes.
// - Codes are 8-bit offset binary, MSB first; code zero is the low reference.
// - Data writes commit on the 26th serial clock rising edge, copy commands on the 18th; aborted transfers change nothing.
`default_nettype none
package ddmpc_pkg;

   localparam int unsigned NUM_CH       = 2;
   localparam int unsigned CODE_W       = 8;
   localparam int unsigned STRAP_W      = 4;

   localparam logic [2:0]  SLAVE_PREFIX = 3'h2;
   localparam logic [3:0]  BIT_LAST     = 4'h7;
   localparam logic [3:0]  ACK_SLOT     = 4'h8;
   localparam logic [1:0]  BYTE_ADDR    = 2'h0;
   localparam logic [1:0]  BYTE_CMD     = 2'h1;
   localparam logic [1:0]  BYTE_DATA    = 2'h2;
   localparam logic [1:0]  BYTE_SAT     = 2'h3;

   localparam logic [1:0]  OP_WRITE     = 2'h0;
   localparam logic [1:0]  OP_READ      = 2'h2;
   localparam logic [1:0]  COPY_XFER    = 2'h0;
   localparam logic [1:0]  COPY_VOL     = 2'h1;
   localparam logic [1:0]  COPY_NV      = 2'h2;
   localparam logic [1:0]  COPY_BOTH    = 2'h3;
   localparam logic [3:0]  SEL_CH0      = 4'h0;
   localparam logic [3:0]  SEL_CH1      = 4'h1;
   localparam logic [3:0]  SEL_CTL      = 4'h4;
   localparam logic [3:0]  SEL_ALL      = 4'hF;

   localparam logic [7:0]  CTL_FACTORY  = 8'h00;
   localparam logic [7:0]  CODE_FACTORY = 8'h00;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [7:0]  CODE_LOW_REF = 8'h00;

   localparam int unsigned INIT_TIME_US = 500;
   localparam int unsigned MCLK_MHZ     = 40;
   localparam int unsigned INIT_CYCLES_DEF = INIT_TIME_US * MCLK_MHZ;

   typedef struct packed {
      logic [1:0] op;
      logic [1:0] copy;
      logic [3:0] sel;
   } ddmpc_cmd_t;

   typedef struct packed {
      logic [1:0] ign_hi;
      logic [1:0] mute;
      logic [1:0] ign_lo;
      logic [1:0] pdown;
   } ddmpc_ctl_t;

   typedef struct packed {
      ddmpc_cmd_t  cmd;
      logic [7:0]  data;
   } ddmpc_wr_t;

   typedef struct packed {
      logic [7:0] code;
      logic       muted;
      logic       hiz;
   } ddmpc_chan_t;

   typedef enum logic [1:0] {
      INIT_LOAD,
      INIT_HOLD,
      RUNNING
   } ddmpc_init_t;

endpackage : ddmpc_pkg
`default_nettype wire

// ---- ddmpc_top.sv ----
// Purpose: Serial register slave and output control for a dual 8-bit converter.
// Assumes: scl_i clocks the link logic; mclk_i clocks registers and outputs.
// Notes:   Open-drain data pin is split into sda_i, sda_o and sda_oe_o.
`timescale 1ns/10ps
`default_nettype none
module ddmpc_top
#(
   parameter int unsigned INIT_CYCLES = ddmpc_pkg::INIT_CYCLES_DEF
)
(
   input  wire logic                      mclk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      nv_erase_n_i,
   input  wire logic                      scl_i,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe_o,
   input  wire logic [3:0]                addr_strap_i,
   input  wire logic                      mute_req_i,
   output ddmpc_pkg::ddmpc_chan_t [1:0]   chan_o,
   output logic                           init_busy_o
);
   import ddmpc_pkg::*;

   localparam int unsigned CNT_W = $clog2(INIT_CYCLES + 1);

   if (INIT_CYCLES < 1)
   begin : g_chk
      $error("INIT_CYCLES must be at least one cycle.");
   end

   // System domain: pin synchronisers.
   logic [1:0]          scl_s_r;
   logic [1:0]          sda_s_r;
   logic [1:0]          mute_s_r;
   logic [3:0]          strap_s1_r;
   logic [3:0]          strap_r;
   logic                scl_q_r;
   logic                sda_q_r;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_s_r    <= 2'h3;
         sda_s_r    <= 2'h3;
         mute_s_r   <= 2'h0;
         strap_s1_r <= 4'h0;
         strap_r    <= 4'h0;
         scl_q_r    <= 1'b1;
         sda_q_r    <= 1'b1;
      end
      else
      begin
         scl_s_r    <= {scl_s_r[0], scl_i};
         sda_s_r    <= {sda_s_r[0], sda_i};
         mute_s_r   <= {mute_s_r[0], mute_req_i};
         strap_s1_r <= addr_strap_i;
         strap_r    <= strap_s1_r;
         scl_q_r    <= scl_s_r[1];
         sda_q_r    <= sda_s_r[1];
      end
   end

   // A start or stop holds the link logic in reset until the serial clock is low again,
   // so the bit counters restart cleanly on every start and repeated start.
   logic                link_rst_r;
   logic                link_rst_nxt;
   logic                bus_edge;

   assign bus_edge = scl_s_r[1] & scl_q_r & (sda_s_r[1] ^ sda_q_r);

   always_comb
   begin
      link_rst_nxt = link_rst_r;
      if (bus_edge)
         link_rst_nxt = 1'b1;
      else if (!scl_s_r[1] && sda_q_r == sda_s_r[1] && !sda_s_r[1])
         link_rst_nxt = 1'b0;
      else if (!scl_s_r[1] && link_rst_r && !scl_q_r)
         link_rst_nxt = 1'b0;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         link_rst_r <= 1'b1;
      else
         link_rst_r <= link_rst_nxt;
   end

   logic                link_arst_n;
   assign link_arst_n = nrst_i & ~link_rst_r;

   // Link domain: bit and byte counting, address match, command and commit capture.
   logic [3:0]          bit_cnt_r;
   logic [1:0]          byte_cnt_r;
   logic [6:0]          rx_sh_r;
   logic                matched_r;
   logic                rd_mode_r;
   logic [7:0]          tx_byte_r;
   logic [7:0]          rx_byte;
   ddmpc_cmd_t          cmd_r;
   logic                cmd_tgl_r;
   ddmpc_wr_t           wr_word_r;
   logic                wr_tgl_r;
   logic [7:0]          rd_byte_r;

   assign rx_byte = {rx_sh_r, sda_i};

   always_ff @(posedge scl_i or negedge link_arst_n)
   begin
      if (!link_arst_n)
      begin
         bit_cnt_r  <= 4'h0;
         byte_cnt_r <= BYTE_ADDR;
         rx_sh_r    <= 7'h00;
      end
      else if (bit_cnt_r == ACK_SLOT)
      begin
         bit_cnt_r <= 4'h0;
         if (byte_cnt_r != BYTE_SAT)
            byte_cnt_r <= byte_cnt_r + 2'h1;
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         rx_sh_r   <= rx_byte[6:0];
      end
   end

   always_ff @(posedge scl_i or negedge link_arst_n)
   begin
      if (!link_arst_n)
      begin
         matched_r <= 1'b0;
         rd_mode_r <= 1'b0;
         tx_byte_r <= BYTE_ZERO;
      end
      else if (byte_cnt_r == BYTE_ADDR && bit_cnt_r == BIT_LAST)
      begin
         matched_r <= (rx_byte[7:1] == {SLAVE_PREFIX, strap_r});
         rd_mode_r <= rx_byte[0];
         // Register contents are quasi-static here; the read select settled long ago.
         tx_byte_r <= rd_byte_r;
      end
   end

   // The command survives a repeated start so that a read can follow it.
   always_ff @(posedge scl_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmd_r     <= '0;
         cmd_tgl_r <= 1'b0;
      end
      else if (matched_r && !rd_mode_r && byte_cnt_r == BYTE_CMD && bit_cnt_r == BIT_LAST)
      begin
         cmd_r     <= ddmpc_cmd_t'(rx_byte);
         cmd_tgl_r <= ~cmd_tgl_r;
      end
   end

   always_ff @(posedge scl_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_word_r <= '0;
         wr_tgl_r  <= 1'b0;
      end
      else if (matched_r && !rd_mode_r && cmd_r.op == OP_WRITE)
      begin
         if (cmd_r.copy == COPY_XFER && byte_cnt_r == BYTE_CMD && bit_cnt_r == ACK_SLOT)
         begin
            wr_word_r <= '{cmd: cmd_r, data: BYTE_ZERO};
            wr_tgl_r  <= ~wr_tgl_r;
         end
         else if (cmd_r.copy != COPY_XFER && byte_cnt_r == BYTE_DATA &&
                  bit_cnt_r == BIT_LAST)
         begin
            wr_word_r <= '{cmd: cmd_r, data: rx_byte};
            wr_tgl_r  <= ~wr_tgl_r;
         end
      end
   end

   // Data pin changes on falling edges so it is stable while the clock is high.
   logic                drive_low_r;

   always_ff @(negedge scl_i or negedge link_arst_n)
   begin
      if (!link_arst_n)
         drive_low_r <= 1'b0;
      else if (bit_cnt_r == ACK_SLOT)
         drive_low_r <= matched_r && (byte_cnt_r == BYTE_ADDR || !rd_mode_r);
      else if (matched_r && rd_mode_r && byte_cnt_r == BYTE_CMD)
         drive_low_r <= ~tx_byte_r[3'(BIT_LAST - bit_cnt_r)];
      else
         drive_low_r <= 1'b0;
   end

   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_low_r;

   // System domain: toggle crossings for command and commit events.
   logic [2:0]          cmd_sync_r;
   logic [2:0]          wr_sync_r;
   ddmpc_cmd_t          rd_sel_r;
   logic                wr_evt;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmd_sync_r <= 3'h0;
         wr_sync_r  <= 3'h0;
      end
      else
      begin
         cmd_sync_r <= {cmd_sync_r[1:0], cmd_tgl_r};
         wr_sync_r  <= {wr_sync_r[1:0], wr_tgl_r};
      end
   end

   assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_sel_r <= '0;
      else if (cmd_sync_r[2] ^ cmd_sync_r[1])
         rd_sel_r <= cmd_r;
   end

   // Power-on sequence: load volatile copies, then hold outputs muted.
   ddmpc_init_t         init_st_r;
   logic [CNT_W-1:0]    init_cnt_r;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         init_st_r  <= INIT_LOAD;
         init_cnt_r <= '0;
      end
      else
      begin
         case (init_st_r)
            INIT_LOAD: init_st_r <= INIT_HOLD;
            INIT_HOLD:
            begin
               init_cnt_r <= init_cnt_r + CNT_W'(1);
               if (init_cnt_r == CNT_W'(INIT_CYCLES - 1))
                  init_st_r <= RUNNING;
            end
            RUNNING:   init_st_r <= RUNNING;
            default:   init_st_r <= INIT_LOAD;
         endcase
      end
   end

   assign init_busy_o = (init_st_r != RUNNING);

   // Retained copies: cleared only by the erase input, never by power-on reset.
   logic [7:0]          nv_code_r [NUM_CH];
   ddmpc_ctl_t          nv_ctl_r;
   logic [7:0]          act_code_r [NUM_CH];
   ddmpc_ctl_t          act_ctl_r;
   ddmpc_ctl_t          wr_ctl;
   ddmpc_ctl_t          wr_raw;
   logic                wr_nv;
   logic                wr_vol;
   logic                xfer;

   assign wr_raw = ddmpc_ctl_t'(wr_word_r.data);
   assign wr_ctl = '{ign_hi: 2'h0, mute: wr_raw.mute, ign_lo: 2'h0,
                     pdown: wr_raw.pdown};
   assign xfer   = wr_evt && wr_word_r.cmd.copy == COPY_XFER;
   assign wr_nv  = wr_evt && wr_word_r.cmd.copy[1];
   assign wr_vol = wr_evt && wr_word_r.cmd.copy[0];

   always_ff @(posedge mclk_i or negedge nv_erase_n_i)
   begin
      if (!nv_erase_n_i)
         nv_ctl_r <= ddmpc_ctl_t'(CTL_FACTORY);
      else if (wr_nv && wr_word_r.cmd.sel == SEL_CTL)
         nv_ctl_r <= wr_ctl;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         act_ctl_r <= ddmpc_ctl_t'(CTL_FACTORY);
      else if (init_st_r == INIT_LOAD)
         act_ctl_r <= nv_ctl_r;
      else if (wr_word_r.cmd.sel == SEL_CTL && (wr_vol || xfer))
         act_ctl_r <= xfer ? nv_ctl_r : wr_ctl;
   end

   genvar ch;
   for (ch = 0; ch < NUM_CH; ch++)
   begin : g_ch
      logic sel_hit;
      logic all_hit;

      assign sel_hit = (wr_word_r.cmd.sel == 4'(ch));
      assign all_hit = (wr_word_r.cmd.sel == SEL_ALL) && wr_word_r.cmd.copy == COPY_VOL;

      always_ff @(posedge mclk_i or negedge nv_erase_n_i)
      begin
         if (!nv_erase_n_i)
            nv_code_r[ch] <= CODE_FACTORY;
         else if (wr_nv && sel_hit)
            nv_code_r[ch] <= wr_word_r.data;
      end

      // Writes land regardless of mute and power-down and never touch those bits.
      always_ff @(posedge mclk_i or negedge nrst_i)
      begin
         if (!nrst_i)
            act_code_r[ch] <= CODE_FACTORY;
         else if (init_st_r == INIT_LOAD)
            act_code_r[ch] <= nv_code_r[ch];
         else if (xfer && sel_hit)
            act_code_r[ch] <= nv_code_r[ch];
         else if (wr_vol && (sel_hit || all_hit))
            act_code_r[ch] <= wr_word_r.data;
      end

      // The external mute only gates the output; stored mute bits stay untouched.
      always_ff @(posedge mclk_i or negedge nrst_i)
      begin
         if (!nrst_i)
            chan_o[ch] <= '{code: CODE_LOW_REF, muted: 1'b1, hiz: 1'b0};
         else
         begin
            chan_o[ch].muted <= init_busy_o || mute_s_r[1] || act_ctl_r.mute[ch];
            chan_o[ch].code  <= (init_busy_o || mute_s_r[1] || act_ctl_r.mute[ch]) ?
                                CODE_LOW_REF : act_code_r[ch];
            chan_o[ch].hiz   <= act_ctl_r.pdown[ch] && !init_busy_o;
         end
      end
   end

   // Read data selection for the next read phase.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_byte_r <= BYTE_ZERO;
      else if (rd_sel_r.op != OP_READ)
         rd_byte_r <= BYTE_ZERO;
      else
      begin
         case ({rd_sel_r.copy, rd_sel_r.sel})
            {COPY_VOL, SEL_CH0}: rd_byte_r <= act_code_r[0];
            {COPY_VOL, SEL_CH1}: rd_byte_r <= act_code_r[1];
            {COPY_VOL, SEL_CTL}: rd_byte_r <= act_ctl_r;
            {COPY_NV, SEL_CH0}:  rd_byte_r <= nv_code_r[0];
            {COPY_NV, SEL_CH1}:  rd_byte_r <= nv_code_r[1];
            {COPY_NV, SEL_CTL}:  rd_byte_r <= nv_ctl_r;
            default:             rd_byte_r <= BYTE_ZERO;
         endcase
      end
   end

endmodule : ddmpc_top
`default_nettype wire

// ---- ddmpc_monitor.sv ----
// Purpose: Concurrent checks on the ports of the converter control block.
// Assumes: One mclk domain; scl_i is watched only as a sign of link activity.
// Notes:   Bound to every ddmpc_top instance at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module ddmpc_monitor
   import ddmpc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = ddmpc_pkg::INIT_CYCLES_DEF
)
(
   input wire logic                  mclk_i,
   input wire logic                  nrst_i,
   input wire logic                  scl_i,
   input wire logic                  sda_o,
   input wire logic                  sda_oe_o,
   input wire logic                  mute_req_i,
   input wire ddmpc_pkg::ddmpc_chan_t [1:0] chan_o,
   input wire logic                  init_busy_o
);
   int unsigned rst_cnt;
   int unsigned quiet;
   default clocking mon_cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rst_cnt <= 0;
      else if (rst_cnt < 32'h000FFFFF)
         rst_cnt <= rst_cnt + 1;
   end
   // Cycles since the last cause that may legally change an output state.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         quiet <= 0;
      else if ($changed(scl_i) || init_busy_o || mute_req_i)
         quiet <= 0;
      else if (quiet < 32'h000000FF)
         quiet <= quiet + 1;
   end
   chk_muted_code: assert property (
      (!chan_o[0].muted || chan_o[0].code == CODE_LOW_REF) &&
      (!chan_o[1].muted || chan_o[1].code == CODE_LOW_REF))
      else $error("muted channel shows a nonzero code");
   chk_init_muted: assert property (init_busy_o |-> chan_o[0].muted && chan_o[1].muted)
      else $error("output not muted during initialisation");
   chk_init_nohiz: assert property (init_busy_o |-> !chan_o[0].hiz && !chan_o[1].hiz)
      else $error("output in high impedance during initialisation");
   chk_init_min: assert property (rst_cnt < INIT_CYCLES |-> init_busy_o)
      else $error("initialisation ended early");
   chk_init_max: assert property (rst_cnt > INIT_CYCLES + 3 |-> !init_busy_o)
      else $error("initialisation did not end");
   chk_ext_mute: assert property (mute_req_i [*4] |-> chan_o[0].muted && chan_o[1].muted)
      else $error("mute input did not mute both channels");
   chk_hiz_cause: assert property (
      $changed(chan_o[0].hiz) || $changed(chan_o[1].hiz) |-> quiet < 40)
      else $error("power-down state changed without a cause");
   chk_unmute_cause: assert property (
      $fell(chan_o[0].muted) || $fell(chan_o[1].muted) |-> quiet < 40)
      else $error("mute cleared without a cause");
   chk_sda_drain: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high while enabled");
   cov_ext_mute: cover property (mute_req_i [*4]);
   cov_pdown: cover property ($rose(chan_o[0].hiz));
   cov_init_end: cover property ($fell(init_busy_o));
endmodule : ddmpc_monitor
bind ddmpc_top ddmpc_monitor #(.INIT_CYCLES(INIT_CYCLES)) ddmpc_monitor_i (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_i), .mute_req_i(mute_req_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .chan_o(chan_o), .init_busy_o(init_busy_o)
);
`default_nettype wire

// ---- ddmpc_host_model.sv ----
// Purpose: Behavioural two-wire bus master driving the serial link.
// Assumes: The data line is pulled up; sda_low_o pulls it low.
// Notes:   The serial clock stands high between frames.
`timescale 1ns/10ps
`default_nettype none
module ddmpc_host_model
(
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   localparam int HP = 300;
   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic start_c;
      sda_low_o = 1'b0;
      #(HP/2) scl_o = 1'b1;
      #HP sda_low_o = 1'b1;
      #HP scl_o = 1'b0;
      #1400;
   endtask : start_c
   task automatic stop_c;
      sda_low_o = 1'b1;
      #(HP/2) scl_o = 1'b1;
      #HP sda_low_o = 1'b0;
      #HP;
   endtask : stop_c
   task automatic put_bit(input logic b, output logic s);
      sda_low_o = ~b;
      #(HP/2) scl_o = 1'b1;
      #(HP/2) s = sda_i;
      #(HP/2) scl_o = 1'b0;
      #(HP/2);
   endtask : put_bit
   // The ninth bit is released, so it reads the acknowledge or sends a NACK.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
      for (int i = 7; i >= 0; i--)
         put_bit(tx[i], rx[i]);
      put_bit(1'b1, ack_n);
   endtask : xfer
   task automatic wr(input logic [7:0] aw, input logic [7:0] cmd, input logic [7:0] d,
                     input bit full, output logic ack_n);
      logic [7:0] rx;
      logic       a;
      start_c;
      xfer(aw, rx, ack_n);
      xfer(cmd, rx, a);
      if (full)
         xfer(d, rx, a);
      stop_c;
   endtask : wr
   task automatic rd(input logic [7:0] aw, input logic [7:0] cmd, output logic [7:0] d);
      logic [7:0] rx;
      logic       a;
      start_c;
      xfer(aw, rx, a);
      xfer(cmd, rx, a);
      start_c;
      xfer(aw | 8'h01, rx, a);
      xfer(8'hFF, d, a);
      stop_c;
   endtask : rd
endmodule : ddmpc_host_model
`default_nettype wire

// ---- ddmpc_top_tb.sv ----
// Purpose: Self-checking bench for the converter mute and power-down control block.
// Assumes: Registers are reached only through the serial host model.
// Notes:   INIT_CYCLES is shortened so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
module ddmpc_top_tb;
   import ddmpc_pkg::*;
   localparam int unsigned INIT_N = 8;
   localparam logic [7:0]  AW     = {SLAVE_PREFIX, 4'h5, 1'b0};
   logic              mclk     = 1'b0;
   logic              nrst_n   = 1'b0;
   logic              erase_n  = 1'b0;
   logic              mute_req = 1'b0;
   logic [3:0]        strap    = 4'h5;
   logic              scl;
   logic              host_low;
   logic              sda_oe;
   logic              init_busy;
   ddmpc_chan_t [1:0] chan;
   wire logic         sda_w = ~(host_low | sda_oe);
   int                n_fail = 0;
   int                tests_run = 0;
   logic [7:0]        exp_code [2] = '{8'h00, 8'h00};
   logic [7:0]        rd_v;
   logic [7:0]        c;
   logic              ack_n;
   always #12.5 mclk = ~mclk;
   ddmpc_top #(.INIT_CYCLES(INIT_N)) ddmpc_top_i (
      .mclk_i(mclk), .nrst_i(nrst_n), .nv_erase_n_i(erase_n), .scl_i(scl), .sda_i(sda_w),
      .sda_o(), .sda_oe_o(sda_oe), .addr_strap_i(strap), .mute_req_i(mute_req),
      .chan_o(chan), .init_busy_o(init_busy));
   ddmpc_host_model ddmpc_host_model_i (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));
   function automatic logic [7:0] wcmd(input logic [1:0] copy, input logic [3:0] sel);
      return {OP_WRITE, copy, sel};
   endfunction : wcmd
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic chk_ch(input int ch, input logic [7:0] cd, input logic m, input logic z);
      check($sformatf("ch%0d code", ch), chan[ch].code, cd);
      check($sformatf("ch%0d muted", ch), {7'h00, chan[ch].muted}, {7'h00, m});
      check($sformatf("ch%0d hiz", ch), {7'h00, chan[ch].hiz}, {7'h00, z});
   endtask : chk_ch
   task automatic put_reg(input logic [7:0] cmd, input logic [7:0] d, input bit full);
      ddmpc_host_model_i.wr(AW, cmd, d, full, ack_n);
      repeat (6) @(negedge mclk);
   endtask : put_reg
   task automatic get_reg(input logic [1:0] copy, input logic [3:0] sel);
      ddmpc_host_model_i.rd(AW, {OP_READ, copy, sel}, rd_v);
   endtask : get_reg
   task automatic wait_init;
      int n;
      n = 0;
      while (init_busy !== 1'b0 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= 100)
      begin
         check("init_busy timeout", {7'h00, init_busy}, 8'h00);
         wrap_up;
      end
      else
         repeat (2) @(negedge mclk);
   endtask : wait_init
   task automatic power_up;
      repeat (3) @(posedge mclk);
      nrst_n  <= 1'b1;
      erase_n <= 1'b1;
      @(negedge mclk);
      check("init_busy", {7'h00, init_busy}, 8'h01);
      chk_ch(0, CODE_LOW_REF, 1'b1, 1'b0);
      wait_init;
   endtask : power_up
   initial
   begin
      void'($urandom(46951));
      power_up;
      chk_ch(0, CODE_FACTORY, 1'b0, 1'b0);
      chk_ch(1, CODE_FACTORY, 1'b0, 1'b0);
      $display("test power-up done");
      put_reg(wcmd(COPY_VOL, SEL_CTL), 8'hE1, 1'b1);
      check("addr ack", {7'h00, ack_n}, 8'h00);
      chk_ch(0, CODE_LOW_REF, 1'b0, 1'b1);
      chk_ch(1, CODE_LOW_REF, 1'b1, 1'b0);
      get_reg(COPY_VOL, SEL_CTL);
      check("control readback", rd_v, 8'hE1 & 8'h33);
      exp_code[1] = 8'($urandom_range(255, 1));
      put_reg(wcmd(COPY_VOL, SEL_CH1), exp_code[1], 1'b1);
      chk_ch(1, CODE_LOW_REF, 1'b1, 1'b0);
      get_reg(COPY_VOL, SEL_CH1);
      check("code readback", rd_v, exp_code[1]);
      put_reg(wcmd(COPY_VOL, SEL_CTL), 8'h00, 1'b1);
      chk_ch(1, exp_code[1], 1'b0, 1'b0);
      chk_ch(0, CODE_LOW_REF, 1'b0, 1'b0);
      $display("test mute and power-down done");
      @(posedge mclk);
      mute_req <= 1'b1;
      repeat (6) @(negedge mclk);
      chk_ch(0, CODE_LOW_REF, 1'b1, 1'b0);
      chk_ch(1, CODE_LOW_REF, 1'b1, 1'b0);
      get_reg(COPY_VOL, SEL_CTL);
      check("control under mute input", rd_v, 8'h00);
      @(posedge mclk);
      mute_req <= 1'b0;
      repeat (6) @(negedge mclk);
      chk_ch(1, exp_code[1], 1'b0, 1'b0);
      $display("test mute input done");
      put_reg(wcmd(COPY_VOL, SEL_CH1), ~exp_code[1], 1'b0);
      chk_ch(1, exp_code[1], 1'b0, 1'b0);
      ddmpc_host_model_i.wr(AW ^ 8'h02, wcmd(COPY_VOL, SEL_CH1), ~exp_code[1], 1'b1, ack_n);
      check("foreign address ack", {7'h00, ack_n}, 8'h01);
      chk_ch(1, exp_code[1], 1'b0, 1'b0);
      $display("test abort done");
      for (int i = 0; i < 4; i++)
      begin
         c = (i == 0) ? 8'hFF : 8'($urandom_range(255, 1));
         exp_code[i % 2] = c;
         put_reg(wcmd(COPY_BOTH, i[0] ? SEL_CH1 : SEL_CH0), c, 1'b1);
         chk_ch(i % 2, c, 1'b0, 1'b0);
         get_reg(COPY_NV, i[0] ? SEL_CH1 : SEL_CH0);
         check("retained code", rd_v, c);
      end
      $display("test codes done");
      put_reg(wcmd(COPY_NV, SEL_CTL), 8'h12, 1'b1);
      chk_ch(0, exp_code[0], 1'b0, 1'b0);
      get_reg(COPY_NV, SEL_CTL);
      check("retained control", rd_v, 8'h12);
      put_reg(wcmd(COPY_XFER, SEL_CTL), 8'h00, 1'b0);
      chk_ch(0, CODE_LOW_REF, 1'b1, 1'b0);
      check("ch1 hiz", {7'h00, chan[1].hiz}, 8'h01);
      put_reg(wcmd(COPY_VOL, SEL_CTL), 8'h00, 1'b1);
      chk_ch(0, exp_code[0], 1'b0, 1'b0);
      @(posedge mclk);
      nrst_n <= 1'b0;
      power_up;
      chk_ch(0, CODE_LOW_REF, 1'b1, 1'b0);
      check("ch1 hiz", {7'h00, chan[1].hiz}, 8'h01);
      get_reg(COPY_VOL, SEL_CH0);
      check("reloaded code", rd_v, exp_code[0]);
      get_reg(COPY_VOL, SEL_CTL);
      check("reloaded control", rd_v, 8'h12);
      $display("test power cycle done");
      c = exp_code[1] ^ 8'($urandom_range(255, 1));
      put_reg(wcmd(COPY_VOL, SEL_ALL), c, 1'b1);
      put_reg(wcmd(COPY_VOL, SEL_CTL), 8'h00, 1'b1);
      chk_ch(0, c, 1'b0, 1'b0);
      chk_ch(1, c, 1'b0, 1'b0);
      put_reg({2'h1, COPY_VOL, SEL_CH0}, ~c, 1'b1);
      chk_ch(0, c, 1'b0, 1'b0);
      put_reg(wcmd(COPY_XFER, SEL_CH1), 8'h00, 1'b0);
      chk_ch(1, exp_code[1], 1'b0, 1'b0);
      chk_ch(0, c, 1'b0, 1'b0);
      $display("test broadcast and transfer done");
      wrap_up;
   end
endmodule : ddmpc_top_tb
`default_nettype wire
